// *** pafs_pkg.sv ***
// Package of register offsets, fields and types for the pin mux block
package pafs_pkg;

  // Register word indices on address bits 5:2 (one aligned 32-bit word each)
  localparam logic [3:0] OFS_SEGS   = 4'h0; // segment select, ports 8..15
  localparam logic [3:0] OFS_P2S    = 4'h1; // port-2 segment select
  localparam logic [3:0] OFS_SWC    = 4'h2; // input switch control
  localparam logic [3:0] OFS_PF1    = 4'h3; // port-1 serial out selects
  localparam logic [3:0] OFS_OSC    = 4'h4; // clock mode select
  localparam logic [3:0] OFS_ADC    = 4'h5; // adc port config/channel/ds
  localparam logic [3:0] OFS_PM     = 4'h6; // port mode, ports 2,4,11
  localparam logic [3:0] OFS_PL     = 4'h7; // output latch, ports 2,4,11
  localparam logic [3:0] OFS_STAT   = 4'h8; // pin input snapshot
  localparam logic [3:0] OFS_LCD    = 4'h9; // debug pin enable, bit 0

  // Reset values
  localparam logic [7:0] RST_OSC    = 8'h00;
  localparam logic [7:0] RST_PM     = 8'hFF;
  localparam logic [7:0] RST_ZERO   = 8'h00;

  // Input switch bit positions
  localparam int SWC_IRQ0   = 0;
  localparam int SWC_CAPT   = 1;
  localparam int SWC_GATE   = 2;
  localparam int SWC_UART2  = 3;
  localparam int SWC_ALT4   = 4;
  localparam int SWC_ALT5   = 5;

  // PF1 bit positions
  localparam int PF1_SO13   = 3;
  localparam int PF1_SO16   = 6;

  // Clock mode select bits
  localparam int OSC_EXCLK  = 7;
  localparam int OSC_X1SEL  = 6;
  localparam int OSC_XTSEL  = 4;

  // Port-2 role
  typedef enum logic [3:0] {
    P2_PORT   = 4'b0001,
    P2_ANALOG = 4'b0010,
    P2_DSIG   = 4'b0100,
    P2_SEG    = 4'b1000
  } pafs_p2_role_t;

  // Analog control bundle
  typedef struct packed {
    logic [3:0] port_cfg;   // pins at or above this are digital
    logic [2:0] chan_sel;
    logic       ds_enable;
  } pafs_adc_t;

endpackage : pafs_pkg

// *** pafs_pin_mux.sv ***
// Pin multiplexer for the upper ports with Avalon-MM control registers
// Functional notes
// - P112 drives uart2 transmit: no seg, switch3 set, 4/5 clear, out, latch 1
// - Switch bit one routes uart2 receive into timer00 capture input
// - Switch bit zero routes uart2 receive into external irq zero
// - Switch bit two lets timer h2 output gate timer 52 input enable
// - Quarter bias makes P40 the third lcd reference, else port/key input
// - Clock mode select resets to zero; oscillator pins then plain inputs
// - Port-2 role from function, adc config, direction, channel, delta-sigma
// - Switchable functions reach pins only via input switch bits
// - Main oscillator pins double as debug mode inputs when debugging
//
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
module pafs_pin_mux #(
  parameter int P2_PINS = 8
) (
  // Clock, reset, enable
  input  wire logic                 clk_sys_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 ce_i,
  // Avalon-MM slave
  input  wire logic [5:0]           avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [3:0]           avs_byteenable_i,
  input  wire logic [31:0]          avs_writedata_i,
  output logic      [31:0]          avs_readdata_o,
  output logic                      avs_waitrequest_o,
  // Pin inputs (asynchronous)
  input  wire logic [P2_PINS-1:0]   port2_pin_i,
  input  wire logic [7:0]           port4_pin_i,
  input  wire logic [1:0]           port11_pin_i,
  input  wire logic [4:0]           port12_pin_i,
  // Peripheral sources (same clock)
  input  wire logic                 uart2_transmit_i,
  input  wire logic                 timer_h2_i,
  input  wire logic [1:0]           lcd_bias_i,
  // Pin drive
  output logic [P2_PINS-1:0]        port2_out_o,
  output logic [P2_PINS-1:0]        port2_oe_n_o,
  output logic [7:0]                port4_out_o,
  output logic [7:0]                port4_oe_n_o,
  output logic [1:0]                port11_out_o,
  output logic [1:0]                port11_oe_n_o,
  output logic [P2_PINS-1:0]        port2_seg_en_o,
  output logic [1:0]                port11_seg_en_o,
  output logic                      pin40_lcd_ref_o,
  // Peripheral inputs
  output logic                      uart2_receive_o,
  output logic                      timer00_capture_input_o,
  output logic                      external_irq0_o,
  output logic                      timer_8bit_52_gate_o,
  output logic                      key_irq_input0_o,
  output logic [P2_PINS-1:0]        port2_analog_en_o,
  output logic [P2_PINS-1:0]        port2_dsig_en_o,
  output logic                      x1_osc_en_o,
  output logic                      exclk_en_o,
  output logic                      xt1_osc_en_o,
  output logic                      debug_mode_pin_a_o,
  output logic                      debug_mode_pin_b_o
);

  // Registers
  logic [7:0]            all_port_function_select_q;
  logic [7:0]            port2_function_select_q;
  logic [7:0]            input_switch_control_q;
  logic [7:0]            pf1_q;
  logic [7:0]            clock_mode_select_q;
  pafs_pkg::pafs_adc_t   adc_q;
  logic [7:0]            port2_direction_q;
  logic [7:0]            port4_direction_q;
  logic [1:0]            port11_direction_q;
  logic [7:0]            port2_latch_q;
  logic [7:0]            port4_latch_q;
  logic [1:0]            port11_latch_q;
  logic                  debug_en_q;

  // Synchronisers
  logic [P2_PINS-1:0]    p2_s1_q, p2_s2_q;
  logic [7:0]            p4_s1_q, p4_s2_q;
  logic [1:0]            p11_s1_q, p11_s2_q;
  logic [4:0]            p12_s1_q, p12_s2_q;

  logic [3:0]  word;
  logic        hit;
  logic [7:0]  wd;
  logic        wr;
  assign word = avs_address_i[5:2];
  assign hit  = avs_address_i[1:0] == 2'b00;
  assign wd   = avs_writedata_i[7:0];
  // Write lands only at the edge that acknowledges it
  assign wr   = ce_i && avs_write_i && !avs_waitrequest_o && hit &&
                avs_byteenable_i[0];

  // Two-stage pin synchroniser
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      p2_s1_q  <= '0;
      p2_s2_q  <= '0;
      p4_s1_q  <= 8'h00;
      p4_s2_q  <= 8'h00;
      p11_s1_q <= 2'h0;
      p11_s2_q <= 2'h0;
      p12_s1_q <= 5'h00;
      p12_s2_q <= 5'h00;
    end else if (ce_i) begin
      p2_s1_q  <= port2_pin_i;
      p2_s2_q  <= p2_s1_q;
      p4_s1_q  <= port4_pin_i;
      p4_s2_q  <= p4_s1_q;
      p11_s1_q <= port11_pin_i;
      p11_s2_q <= p11_s1_q;
      p12_s1_q <= port12_pin_i;
      p12_s2_q <= p12_s1_q;
    end
  end

  // Bus handshake: one wait cycle, then acknowledge
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (ce_i) begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) &&
                             avs_waitrequest_o);
    end
  end

  // Register writes
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      all_port_function_select_q <= pafs_pkg::RST_ZERO;
      port2_function_select_q    <= pafs_pkg::RST_ZERO;
      input_switch_control_q     <= pafs_pkg::RST_ZERO;
      pf1_q                      <= pafs_pkg::RST_ZERO;
      clock_mode_select_q        <= pafs_pkg::RST_OSC;
      adc_q                      <= '0;
      port2_direction_q          <= pafs_pkg::RST_PM;
      port4_direction_q          <= pafs_pkg::RST_PM;
      port11_direction_q         <= 2'h3;
      port2_latch_q              <= pafs_pkg::RST_ZERO;
      port4_latch_q              <= pafs_pkg::RST_ZERO;
      port11_latch_q             <= 2'h0;
      debug_en_q                 <= 1'b0;
    end else if (wr) begin
      unique case (word)
        pafs_pkg::OFS_SEGS:  all_port_function_select_q <= wd;
        pafs_pkg::OFS_P2S:   port2_function_select_q    <= wd;
        pafs_pkg::OFS_SWC:   input_switch_control_q     <= wd;
        pafs_pkg::OFS_PF1:   pf1_q                      <= wd;
        pafs_pkg::OFS_OSC:   clock_mode_select_q        <= wd;
        pafs_pkg::OFS_ADC:   adc_q                      <= wd;
        pafs_pkg::OFS_PM: begin
          port2_direction_q  <= wd;
          port4_direction_q  <= avs_writedata_i[15:8];
          port11_direction_q <= avs_writedata_i[17:16];
        end
        pafs_pkg::OFS_PL: begin
          port2_latch_q  <= wd;
          port4_latch_q  <= avs_writedata_i[15:8];
          port11_latch_q <= avs_writedata_i[17:16];
        end
        pafs_pkg::OFS_LCD:   debug_en_q <= wd[0];
        default: ;
      endcase
    end
  end

  // Read data, zero for unmapped words
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i && avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= 32'h0000_0000;
      if (hit) begin
        unique case (word)
          pafs_pkg::OFS_SEGS:  avs_readdata_o[7:0] <=
                                 all_port_function_select_q;
          pafs_pkg::OFS_P2S:   avs_readdata_o[7:0] <= port2_function_select_q;
          pafs_pkg::OFS_SWC:   avs_readdata_o[7:0] <= input_switch_control_q;
          pafs_pkg::OFS_PF1:   avs_readdata_o[7:0] <= pf1_q;
          pafs_pkg::OFS_OSC:   avs_readdata_o[7:0] <= clock_mode_select_q;
          pafs_pkg::OFS_ADC:   avs_readdata_o[7:0] <= adc_q;
          pafs_pkg::OFS_PM:    avs_readdata_o[17:0] <= {port11_direction_q,
                                 port4_direction_q, port2_direction_q};
          pafs_pkg::OFS_PL:    avs_readdata_o[17:0] <= {port11_latch_q,
                                 port4_latch_q, port2_latch_q};
          pafs_pkg::OFS_STAT:  avs_readdata_o[22:0] <= {p12_s2_q, p11_s2_q,
                                 p4_s2_q, p2_s2_q};
          pafs_pkg::OFS_LCD:   avs_readdata_o[0] <= debug_en_q;
          default: ;
        endcase
      end
    end
  end

  // Port 2 role per pin
  pafs_pkg::pafs_p2_role_t p2_role [P2_PINS];
  genvar gi;
  generate
    for (gi = 0; gi < P2_PINS; gi++) begin : g_p2
      always_comb begin
        if (port2_function_select_q[gi]) begin
          p2_role[gi] = pafs_pkg::P2_SEG;
        end else if (gi >= adc_q.port_cfg || !port2_direction_q[gi]) begin
          p2_role[gi] = pafs_pkg::P2_PORT;
        end else if (adc_q.ds_enable && gi >= adc_q.chan_sel * 2) begin
          p2_role[gi] = pafs_pkg::P2_DSIG;
        end else begin
          p2_role[gi] = pafs_pkg::P2_ANALOG;
        end
      end
      // Port 2 pin drive
      always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          port2_out_o[gi]       <= 1'b0;
          port2_oe_n_o[gi]      <= 1'b1;
          port2_seg_en_o[gi]    <= 1'b0;
          port2_analog_en_o[gi] <= 1'b0;
          port2_dsig_en_o[gi]   <= 1'b0;
        end else if (ce_i) begin
          port2_seg_en_o[gi]    <= p2_role[gi] == pafs_pkg::P2_SEG;
          port2_analog_en_o[gi] <= p2_role[gi] == pafs_pkg::P2_ANALOG;
          port2_dsig_en_o[gi]   <= p2_role[gi] == pafs_pkg::P2_DSIG;
          port2_out_o[gi]       <= port2_latch_q[gi];
          port2_oe_n_o[gi]      <= !(p2_role[gi] == pafs_pkg::P2_PORT &&
                                     !port2_direction_q[gi]);
        end
      end
    end
  endgenerate

  // Port 11: segments or uart2 pins
  logic uart2_sel;
  logic p112_seg;
  logic p113_seg;
  assign uart2_sel = input_switch_control_q[pafs_pkg::SWC_UART2] &&
                     !input_switch_control_q[pafs_pkg::SWC_ALT4] &&
                     !input_switch_control_q[pafs_pkg::SWC_ALT5];
  assign p112_seg  = all_port_function_select_q[3];
  assign p113_seg  = all_port_function_select_q[4];

  // Port 11 drive and segment enables
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port11_out_o    <= 2'h0;
      port11_oe_n_o   <= 2'h3;
      port11_seg_en_o <= 2'h0;
    end else if (ce_i) begin
      port11_seg_en_o <= {p113_seg, p112_seg};
      port11_out_o[0] <= (uart2_sel && port11_latch_q[0]) ?
                         uart2_transmit_i : port11_latch_q[0];
      port11_out_o[1] <= port11_latch_q[1];
      port11_oe_n_o[0] <= p112_seg || port11_direction_q[0];
      port11_oe_n_o[1] <= p113_seg || port11_direction_q[1];
    end
  end

  // Port 4: key inputs, or lcd reference on pin 0
  logic quarter_bias;
  assign quarter_bias = lcd_bias_i == 2'h3;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port4_out_o      <= 8'h00;
      port4_oe_n_o     <= 8'hFF;
      pin40_lcd_ref_o  <= 1'b0;
      key_irq_input0_o <= 1'b0;
    end else if (ce_i) begin
      port4_out_o      <= port4_latch_q;
      port4_oe_n_o     <= port4_direction_q | {7'h00, quarter_bias};
      pin40_lcd_ref_o  <= quarter_bias;
      key_irq_input0_o <= !quarter_bias && p4_s2_q[0];
    end
  end

  // Peripheral input routing
  logic rx_pin;
  assign rx_pin = uart2_sel && !p113_seg && port11_direction_q[1] &&
                  p11_s2_q[1];

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      uart2_receive_o         <= 1'b1;
      timer00_capture_input_o <= 1'b0;
      external_irq0_o         <= 1'b0;
      timer_8bit_52_gate_o    <= 1'b1;
    end else if (ce_i) begin
      uart2_receive_o <= uart2_sel ? rx_pin : 1'b1;
      timer00_capture_input_o <=
        input_switch_control_q[pafs_pkg::SWC_CAPT] ? rx_pin
                                                   : 1'b0;
      external_irq0_o <=
        input_switch_control_q[pafs_pkg::SWC_IRQ0] ? rx_pin
                                                   : p12_s2_q[0];
      timer_8bit_52_gate_o <=
        input_switch_control_q[pafs_pkg::SWC_GATE] ? timer_h2_i
                                                   : 1'b1;
    end
  end

  // Oscillator and debug pin roles
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      x1_osc_en_o        <= 1'b0;
      exclk_en_o         <= 1'b0;
      xt1_osc_en_o       <= 1'b0;
      debug_mode_pin_a_o <= 1'b0;
      debug_mode_pin_b_o <= 1'b0;
    end else if (ce_i) begin
      x1_osc_en_o  <= clock_mode_select_q[pafs_pkg::OSC_X1SEL] &&
                      !clock_mode_select_q[pafs_pkg::OSC_EXCLK];
      exclk_en_o   <= clock_mode_select_q[pafs_pkg::OSC_X1SEL] &&
                      clock_mode_select_q[pafs_pkg::OSC_EXCLK];
      xt1_osc_en_o <= clock_mode_select_q[pafs_pkg::OSC_XTSEL];
      debug_mode_pin_a_o <= debug_en_q && p12_s2_q[1];
      debug_mode_pin_b_o <= debug_en_q && p12_s2_q[2];
    end
  end

endmodule : pafs_pin_mux

// *** pafs_pin_mux_checker.sv ***
// Concurrent checks on the pin mux ports
`timescale 1ns/100ps
module pafs_pin_mux_checker #(
  parameter int P2_PINS = 8
) (
  // Clock and reset
  input wire logic               clk_sys_i,
  input wire logic               arst_n_i,
  input wire logic               ce_i,
  // Bus handshake
  input wire logic               avs_read_i,
  input wire logic               avs_write_i,
  input wire logic               avs_waitrequest_o,
  // Sources
  input wire logic               timer_h2_i,
  input wire logic [1:0]         lcd_bias_i,
  // Pin and routing outputs
  input wire logic [P2_PINS-1:0] port2_oe_n_o,
  input wire logic [P2_PINS-1:0] port2_seg_en_o,
  input wire logic [P2_PINS-1:0] port2_analog_en_o,
  input wire logic [P2_PINS-1:0] port2_dsig_en_o,
  input wire logic [1:0]         port11_oe_n_o,
  input wire logic [1:0]         port11_seg_en_o,
  input wire logic               pin40_lcd_ref_o,
  input wire logic               key_irq_input0_o,
  input wire logic               uart2_receive_o,
  input wire logic               timer00_capture_input_o,
  input wire logic               timer_8bit_52_gate_o,
  input wire logic               x1_osc_en_o,
  input wire logic               exclk_en_o,
  input wire logic               xt1_osc_en_o
);
  // One clock domain for every check
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  // Bus answer timing
  wait_one_a: assert property (!avs_waitrequest_o && ce_i |=>
    avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  answer_next_a: assert property ((avs_read_i || avs_write_i) && ce_i &&
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered next cycle");
  // Pin roles
  seg_release_a: assert property (
    (port11_seg_en_o & ~port11_oe_n_o) == 2'h0)
    else $error("segment pin still driven");
  lcd_ref_a: assert property ((lcd_bias_i == 2'h3 && ce_i) [*4] |->
    pin40_lcd_ref_o && !key_irq_input0_o)
    else $error("quarter bias not giving reference");
  lcd_port_a: assert property ((lcd_bias_i != 2'h3 && ce_i) [*2] |->
    !pin40_lcd_ref_o)
    else $error("reference held outside quarter bias");
  gate_src_a: assert property ($past(ce_i) && !timer_8bit_52_gate_o |->
    !$past(timer_h2_i))
    else $error("timer gate low without source");
  clk_reset_a: assert property ($rose(arst_n_i) |->
    !(x1_osc_en_o || exclk_en_o || xt1_osc_en_o))
    else $error("oscillator mode set out of reset");
  p2_roles_a: assert property (((port2_seg_en_o & port2_analog_en_o) |
    (port2_seg_en_o & port2_dsig_en_o) |
    (port2_dsig_en_o & port2_analog_en_o) |
    ((port2_analog_en_o | port2_dsig_en_o) & ~port2_oe_n_o)) == '0)
    else $error("port2 roles overlap");
  capture_src_a: assert property (timer00_capture_input_o |->
    uart2_receive_o || $past(uart2_receive_o))
    else $error("capture high without receive line");
endmodule : pafs_pin_mux_checker

bind pafs_pin_mux pafs_pin_mux_checker #(.P2_PINS(P2_PINS)) u_chk (
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .timer_h2_i(timer_h2_i),
  .lcd_bias_i(lcd_bias_i), .port2_oe_n_o(port2_oe_n_o),
  .port2_seg_en_o(port2_seg_en_o), .port2_analog_en_o(port2_analog_en_o),
  .port2_dsig_en_o(port2_dsig_en_o), .port11_oe_n_o(port11_oe_n_o),
  .port11_seg_en_o(port11_seg_en_o), .pin40_lcd_ref_o(pin40_lcd_ref_o),
  .key_irq_input0_o(key_irq_input0_o), .uart2_receive_o(uart2_receive_o),
  .timer00_capture_input_o(timer00_capture_input_o),
  .timer_8bit_52_gate_o(timer_8bit_52_gate_o), .x1_osc_en_o(x1_osc_en_o),
  .exclk_en_o(exclk_en_o), .xt1_osc_en_o(xt1_osc_en_o));

// *** port_alternate_function_select_tb_top.sv ***
// Self-checking bench for the pin mux block
`timescale 1ns/100ps
module port_alternate_function_select_tb_top;
  logic        clk_sys_i, arst_n_i, avs_read_i, avs_write_i;
  logic        avs_waitrequest_o, uart2_transmit_i, timer_h2_i;
  logic [5:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, r;
  logic [7:0]  port2_pin_i, port4_pin_i, p2_oe_n, p2_seg, p2_ana, p2_ds;
  logic [7:0]  p2_out, p4_out, p4_oe_n;
  logic [4:0]  port12_pin_i;
  logic [1:0]  port11_pin_i, lcd_bias_i, p11_out, p11_oe_n, p11_seg;
  logic        lcd_ref, key0, rx, capt, irq0, gate, x1, exck, xt1, dbg_a;
  logic        dbg_b, ce_i;
  logic [31:0] exp_q[$];
  int          error_cnt, num_checks, seed;

  pafs_pin_mux u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .ce_i(ce_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_byteenable_i(4'hF),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .port2_pin_i(port2_pin_i),
    .port4_pin_i(port4_pin_i), .port11_pin_i(port11_pin_i),
    .port12_pin_i(port12_pin_i), .uart2_transmit_i(uart2_transmit_i),
    .timer_h2_i(timer_h2_i), .lcd_bias_i(lcd_bias_i), .port2_out_o(p2_out),
    .port2_oe_n_o(p2_oe_n), .port4_out_o(p4_out), .port4_oe_n_o(p4_oe_n),
    .port11_out_o(p11_out), .port11_oe_n_o(p11_oe_n),
    .port2_seg_en_o(p2_seg), .port11_seg_en_o(p11_seg),
    .pin40_lcd_ref_o(lcd_ref), .uart2_receive_o(rx),
    .timer00_capture_input_o(capt), .external_irq0_o(irq0),
    .timer_8bit_52_gate_o(gate), .key_irq_input0_o(key0),
    .port2_analog_en_o(p2_ana), .port2_dsig_en_o(p2_ds), .x1_osc_en_o(x1),
    .exclk_en_o(exck), .xt1_osc_en_o(xt1), .debug_mode_pin_a_o(dbg_a),
    .debug_mode_pin_b_o(dbg_b));

  // Clock, 40 ns period
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // One bus cycle, held until waitrequest is seen low
  task automatic xfer(logic wr, logic [3:0] idx, logic [31:0] wd);
    int n;
    n = 0;
    avs_address_i <= {idx, 2'b00};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= wd;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) error_cnt++;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : xfer

  task automatic wr(logic [3:0] idx, logic [31:0] wd);
    xfer(1'b1, idx, wd);
  endtask : wr

  task automatic rd(logic [3:0] idx, logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, idx, 32'h0);
  endtask : rd

  task automatic w(int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : w

  // Read results against the oldest note
  always @(posedge clk_sys_i) begin
    if (arst_n_i && avs_read_i && avs_waitrequest_o === 1'b0) begin
      if (exp_q.size() == 0) error_cnt++;
      else chk("readdata", exp_q.pop_front(), avs_readdata_o);
    end
  end

  // Watchdog
  initial begin
    w(20000);
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial begin
    seed = 51;
    {arst_n_i, avs_read_i, avs_write_i, uart2_transmit_i, timer_h2_i} = '0;
    {avs_address_i, avs_writedata_i, port2_pin_i, port12_pin_i} = '0;
    port4_pin_i = 8'hFF;
    port11_pin_i = 2'h3;
    lcd_bias_i = 2'h0;
    ce_i = 1'b1;
    w(8);
    arst_n_i <= 1'b1;
    w(1);
    chk("clk_modes", 32'h0, {x1, exck, xt1});
    rd(4'h4, 32'h0);
    rd(4'h6, 32'h0003FFFF);
    rd(4'h2, 32'h0);
    rd(4'hF, 32'h0);
    r = $random(seed);
    wr(4'h3, {24'h0, r[7:0]});
    rd(4'h3, {24'h0, r[7:0]});
    // Transmit line on the shared segment pin
    wr(4'h6, 32'h0002F0FF);
    wr(4'h7, 32'h0001A53C);
    wr(4'h0, 32'h0);
    wr(4'h2, 32'h08);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      uart2_transmit_i <= r[0];
      w(3);
      chk("tx_pin", {r[0], 1'b0}, {p11_out[0], p11_oe_n[0]});
    end
    chk("p4_drive", 32'hF0A5, {p4_oe_n, p4_out});
    chk("p2_out", 32'h3C, p2_out);
    uart2_transmit_i <= 1'b0;
    wr(4'h2, 32'h18);
    w(3);
    chk("tx_off", 32'h2, {p11_out[0], p11_oe_n[0]});
    wr(4'h0, 32'h08);
    w(3);
    chk("seg_pin", 32'h3, {p11_seg[0], p11_oe_n[0]});
    // Receive line routing
    wr(4'h0, 32'h0);
    wr(4'h2, 32'h0B);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      port11_pin_i <= {r[0], 1'b1};
      port12_pin_i <= r[5:1];
      w(6);
      chk("rx_route", {3{r[0]}}, {rx, capt, irq0});
    end
    wr(4'h2, 32'h08);
    w(6);
    chk("rx_own", {1'b0, r[1]}, {capt, irq0});
    // Timer gate
    wr(4'h2, 32'h04);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      timer_h2_i <= r[0];
      w(3);
      chk("gate", r[0], gate);
    end
    timer_h2_i <= 1'b0;
    wr(4'h2, 32'h0);
    w(3);
    chk("gate_off", 32'h1, gate);
    // Bias selects reference or key input
    lcd_bias_i <= 2'h3;
    w(6);
    chk("lcd_ref", 32'h2, {lcd_ref, key0});
    chk("p40_release", 32'hF1, p4_oe_n);
    lcd_bias_i <= 2'h1;
    w(6);
    chk("lcd_port", 32'h1, {lcd_ref, key0});
    chk("p40_drive", 32'hF0, p4_oe_n);
    // Port-2 roles
    wr(4'h1, 32'h0F);
    wr(4'h5, 32'h60);
    w(3);
    chk("p2_roles", 32'h0F3000, {p2_seg, p2_ana, p2_ds});
    wr(4'h5, 32'h63);
    w(3);
    chk("p2_dsig", 32'h0F0030, {p2_seg, p2_ana, p2_ds});
    // Oscillator modes and debug pins
    wr(4'h4, 32'h50);
    w(3);
    chk("clk_x1", 32'h5, {x1, exck, xt1});
    wr(4'h4, 32'hD0);
    w(3);
    chk("clk_modes", 32'h3, {x1, exck, xt1});
    wr(4'h9, 32'h1);
    port12_pin_i <= 5'h02;
    w(6);
    chk("dbg_pin", 32'h2, {dbg_a, dbg_b});
    // Clock enable low freezes the outputs
    ce_i <= 1'b0;
    lcd_bias_i <= 2'h3;
    w(6);
    chk("ce_hold", 32'h0, lcd_ref);
    ce_i <= 1'b1;
    w(3);
    chk("ce_run", 32'h1, lcd_ref);
    conclude();
  end
endmodule : port_alternate_function_select_tb_top
